// >>> hdl/epd_pkg.sv
// Purpose: Shared constants and types for the extended-precision load and format decode
// Assumes: 32-bit words, 32 working registers addressed by a 5-bit index
// Notes:   Opcode field positions are module parameters of the format decoder
`default_nettype none
package epd_pkg;
   // ---------------------------------------------------------------
   // Extended-precision layout
   // ---------------------------------------------------------------
   localparam int          EXT_WORDS       = 4;
   localparam int          WORD_BYTES      = 4;
   localparam logic [31:0] WORD_STEP       = 32'h0000_0004;
   localparam int          SIGN_POS        = 31;
   localparam int          EXP_HI          = 30;
   localparam int          EXP_LO          = 16;
   localparam int          INT_POS         = 31;
   localparam int          FRAC_TOP_POS    = 30;
   localparam logic [15:0] RSV_FIELD_VAL   = 16'h0000;
   localparam logic [31:0] RSV_WORD_VAL    = 32'h0000_0000;
   localparam logic [14:0] EXT_EXP_MAX     = 15'h7FFF;
   localparam logic [15:0] EXT_BIAS        = 16'h3FFF;
   localparam logic [3:0]  EXT_ALIGN_MASK  = 4'hF;
   localparam logic [1:0]  WORD_ALIGN_MASK = 2'h3;
   localparam logic [1:0]  LAST_WORD       = 2'h3;

   // ---------------------------------------------------------------
   // Data access sizes and instruction formats
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      SZ_BYTE = 3'h0, SZ_HALF = 3'h1, SZ_WORD = 3'h2, SZ_DOUBLE = 3'h3, SZ_EXT = 3'h4
   } epd_size_t;

   typedef enum logic [1:0] {
      FMT_NONE = 2'h0, FMT_CALL = 2'h1, FMT_SET_HIGH_BR = 2'h2, FMT_OTHER = 2'h3
   } epd_fmt_t;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0, ST_READ = 1'b1
   } epd_state_t;
endpackage : epd_pkg
`default_nettype wire

// >>> hdl/epd_format_decode.sv
// Purpose: Combinational classification of one instruction word into its format
// Assumes: Word already fetched; field positions given by parameters
// Notes:   No state; the caller registers the results
`default_nettype none
module epd_format_decode #(
   parameter logic [1:0] OP_CALL   = 2'h1,
   parameter logic [1:0] OP_FMT2   = 2'h0,
   parameter int         OP_HI     = 31,
   parameter int         IMM_BIT   = 13,
   parameter int         SRC1_LO   = 14,
   parameter int         SRC2_LO   = 0
) (
   // Instruction
   input  wire logic [31:0]      instrWord,
   // Classification
   output epd_pkg::epd_fmt_t     fmt,
   output logic                  usesImm,
   output logic [4:0]            src1Idx,
   output logic [4:0]            src2Idx
);
   import epd_pkg::*;

   logic [1:0] opField;

   // Format select from the top opcode field
   always_comb begin
      opField = instrWord[OP_HI -: 2];
      if (opField == OP_CALL) begin
         fmt = FMT_CALL;
      end else if (opField == OP_FMT2) begin
         fmt = FMT_SET_HIGH_BR;
      end else begin
         fmt = FMT_OTHER;
      end
   end

   // Operand sources: two registers, or one register plus an in-word constant
   always_comb begin
      src1Idx = instrWord[SRC1_LO +: 5];
      src2Idx = instrWord[SRC2_LO +: 5];
      // Formats 1 and 2 always carry a displacement or immediate
      usesImm = (fmt != FMT_OTHER) || instrWord[IMM_BIT];
   end
endmodule : epd_format_decode
`default_nettype wire

// >>> hdl/epd_ext_load.sv
// Purpose: Extended-precision load sequencer, alignment checks and format decode
// Assumes: Memory answers one word read at a time with memAck and memRdData
// Notes:   Register file writes are one word a cycle; no buffering
//
// Operation
// - A 128-bit extended operand is written into four consecutive registers.
// - First register holds sign, 15-bit biased exponent and 16-bit reserved field.
// - Second register holds integer bit then top 31 fraction bits.
// - Third register holds low 32 fraction bits; fraction totals 63 bits.
// - Fourth register carries no operand content, treated as reserved.
// - An odd destination register number is forced to the even one below.
// - Datum address is its most significant byte; words follow at ascending addresses.
// - Extended datum must sit on a 16-byte boundary, low four bits zero.
// - Misaligned data access for its size raises the alignment trap.
// - Bias 16383; exponent 32767 gives NaN or infinity; fraction top bit quiet.
// - Three formats: call, set-high and branch, everything else.
// - Instructions are one 32-bit word fetched from a word-aligned address.
// - Operands come from two registers or one register plus in-word constant.
`default_nettype none
module epd_ext_load (
   // Clock and reset
   input  wire logic                ref_clk,
   input  wire logic                reset_n,
   // Extended load request
   input  wire logic                extLoadValid,
   input  wire logic [31:0]         extLoadAddr,
   input  wire logic [4:0]          extLoadDest,
   output logic                     extLoadReady,
   // Memory read port
   output logic                     memReq,
   output logic [31:0]              memAddr,
   input  wire logic                memAck,
   input  wire logic [31:0]         memRdData,
   // Register file write port
   output logic                     regWrEn,
   output logic [4:0]               regWrIdx,
   output logic [31:0]              regWrData,
   // Extended load result
   output logic                     extDone,
   output logic                     extIsNan,
   output logic                     extIsSignaling,
   output logic                     extIsInf,
   output logic [15:0]              extExpUnbiased,
   output logic                     extAlignTrap,
   // Generic data access check
   input  wire logic                dataAccValid,
   input  wire epd_pkg::epd_size_t  dataAccSize,
   input  wire logic [31:0]         dataAccAddr,
   output logic                     dataAlignTrap,
   // Instruction decode
   input  wire logic                instrValid,
   input  wire logic [31:0]         fetchAddr,
   input  wire logic [31:0]         instrWord,
   output logic                     instrDone,
   output logic                     fetchAlignTrap,
   output epd_pkg::epd_fmt_t        instrFmt,
   output logic                     instrUsesImm,
   output logic [4:0]               instrSrc1,
   output logic [4:0]               instrSrc2
);
   import epd_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      epd_state_t  st;
      logic [1:0]  wordIdx;
      logic [31:0] base;
      logic [4:0]  dest;
      logic        memReq;
      logic [31:0] memAddr;
      logic        regWrEn;
      logic [4:0]  regWrIdx;
      logic [31:0] regWrData;
      logic [14:0] expo;
      logic        fracTop;
      logic        fracNz;
      logic        done;
      logic        isNan;
      logic        isSnan;
      logic        isInf;
      logic [15:0] expUnb;
      logic        extTrap;
      logic        dataTrap;
      logic        instrDone;
      logic        fetchTrap;
      epd_fmt_t    fmt;
      logic        usesImm;
      logic [4:0]  src1;
      logic [4:0]  src2;
   } epd_state_s_t;

   epd_state_s_t s_reg;
   epd_state_s_t s_next;

   epd_fmt_t     decFmt;
   logic         decImm;
   logic [4:0]   decSrc1;
   logic [4:0]   decSrc2;

   // Misalignment for each access size, low address bits only
   function automatic logic misaligned(input epd_size_t sz, input logic [3:0] a);
      logic bad;
      bad = 1'b0;
      unique case (sz)
         SZ_BYTE:   bad = 1'b0;
         SZ_HALF:   bad = a[0];
         SZ_WORD:   bad = |a[1:0];
         SZ_DOUBLE: bad = |a[2:0];
         SZ_EXT:    bad = |a[3:0];
         default:   bad = 1'b1;                           // Unknown size is refused
      endcase
      return bad;
   endfunction : misaligned

   // ---------------------------------------------------------------
   // Format decoder
   // ---------------------------------------------------------------
   epd_format_decode u_decode (
      .instrWord (instrWord),
      .fmt       (decFmt),
      .usesImm   (decImm),
      .src1Idx   (decSrc1),
      .src2Idx   (decSrc2)
   );

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      logic [14:0] expW;
      logic        nzW;
      expW   = s_reg.expo;
      nzW    = s_reg.fracNz;
      s_next = s_reg;
      // Result strobes last one cycle
      s_next.regWrEn   = 1'b0;
      s_next.done      = 1'b0;
      s_next.extTrap   = 1'b0;
      s_next.dataTrap  = 1'b0;
      s_next.instrDone = 1'b0;
      s_next.fetchTrap = 1'b0;

      // Generic data access alignment check, independent of the sequencer
      if (dataAccValid) begin
         s_next.dataTrap = misaligned(dataAccSize, dataAccAddr[3:0]);
      end

      // Instruction word classification; misaligned fetches decode nothing
      if (instrValid) begin
         s_next.instrDone = 1'b1;
         if (|(fetchAddr[1:0] & WORD_ALIGN_MASK)) begin
            s_next.fetchTrap = 1'b1;
            s_next.fmt       = FMT_NONE;
         end else begin
            s_next.fmt     = decFmt;
            s_next.usesImm = decImm;
            s_next.src1    = decSrc1;
            s_next.src2    = decSrc2;
         end
      end

      unique case (s_reg.st)
         ST_IDLE: begin
            if (extLoadValid) begin
               if (|(extLoadAddr[3:0] & EXT_ALIGN_MASK)) begin
                  // No memory access is made for a misaligned datum
                  s_next.extTrap = 1'b1;
               end else begin
                  s_next.st      = ST_READ;
                  s_next.base    = extLoadAddr;
                  s_next.dest    = {extLoadDest[4:1], 1'b0};
                  s_next.wordIdx = 2'h0;
                  s_next.memReq  = 1'b1;
                  s_next.memAddr = extLoadAddr;
                  s_next.fracNz  = 1'b0;
               end
            end
         end
         ST_READ: begin
            if (memAck) begin
               s_next.regWrEn  = 1'b1;
               // Index wraps at r31; a load to r30 writes its last two words to r0 and r1
               s_next.regWrIdx = 5'(s_reg.dest + {3'h0, s_reg.wordIdx});
               unique case (s_reg.wordIdx)
                  2'h0: begin
                     s_next.regWrData = {memRdData[31:16], RSV_FIELD_VAL};
                     expW = memRdData[EXP_HI:EXP_LO];
                  end
                  2'h1: begin
                     s_next.regWrData = memRdData;
                     s_next.fracTop   = memRdData[FRAC_TOP_POS];
                     nzW = nzW | (|memRdData[FRAC_TOP_POS:0]);
                  end
                  2'h2: begin
                     s_next.regWrData = memRdData;
                     nzW = nzW | (|memRdData);
                  end
                  2'h3: begin
                     s_next.regWrData = RSV_WORD_VAL;
                  end
               endcase
               s_next.expo   = expW;
               s_next.fracNz = nzW;
               if (s_reg.wordIdx == LAST_WORD) begin
                  s_next.st     = ST_IDLE;
                  s_next.memReq = 1'b0;
                  s_next.done   = 1'b1;
                  // Classification over the full 63-bit fraction
                  s_next.isNan  = (s_reg.expo == EXT_EXP_MAX) && s_reg.fracNz;
                  s_next.isSnan = (s_reg.expo == EXT_EXP_MAX) && s_reg.fracNz
                                  && !s_reg.fracTop;
                  s_next.isInf  = (s_reg.expo == EXT_EXP_MAX) && !s_reg.fracNz;
                  s_next.expUnb = {1'b0, s_reg.expo} - EXT_BIAS;
               end else begin
                  s_next.wordIdx = s_reg.wordIdx + 2'h1;
                  // Higher-order words at lower addresses
                  s_next.memAddr = s_reg.memAddr + WORD_STEP;
               end
            end
         end
      endcase
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign extLoadReady   = (s_reg.st == ST_IDLE);
   assign memReq         = s_reg.memReq;
   assign memAddr        = s_reg.memAddr;
   assign regWrEn        = s_reg.regWrEn;
   assign regWrIdx       = s_reg.regWrIdx;
   assign regWrData      = s_reg.regWrData;
   assign extDone        = s_reg.done;
   assign extIsNan       = s_reg.isNan;
   assign extIsSignaling = s_reg.isSnan;
   assign extIsInf       = s_reg.isInf;
   assign extExpUnbiased = s_reg.expUnb;
   assign extAlignTrap   = s_reg.extTrap;
   assign dataAlignTrap  = s_reg.dataTrap;
   assign instrDone      = s_reg.instrDone;
   assign fetchAlignTrap = s_reg.fetchTrap;
   assign instrFmt       = s_reg.fmt;
   assign instrUsesImm   = s_reg.usesImm;
   assign instrSrc1      = s_reg.src1;
   assign instrSrc2      = s_reg.src2;
endmodule : epd_ext_load
`default_nettype wire

// >>> hdl/README_unused.sv
`default_nettype none
`default_nettype wire

// >>> bench/epd_ext_load_props.sv
// Purpose: Concurrent checks on the extended load and format decode ports
// Assumes: One clock domain, reset_n asynchronous and active low
// Notes:   Bound below to every epd_ext_load instance
`default_nettype none
module epd_ext_load_props (
   // Clock and reset
   input wire logic               ref_clk,
   input wire logic               reset_n,
   // Extended load and memory
   input wire logic               extLoadValid,
   input wire logic [31:0]        extLoadAddr,
   input wire logic               extLoadReady,
   input wire logic               memReq,
   input wire logic [31:0]        memAddr,
   input wire logic               memAck,
   input wire logic               regWrEn,
   input wire logic [4:0]         regWrIdx,
   input wire logic [31:0]        regWrData,
   input wire logic               extDone,
   input wire logic               extAlignTrap,
   // Data check and decode
   input wire logic               dataAccValid,
   input wire epd_pkg::epd_size_t dataAccSize,
   input wire logic [31:0]        dataAccAddr,
   input wire logic               dataAlignTrap,
   input wire logic               instrValid,
   input wire logic [31:0]        fetchAddr,
   input wire logic [31:0]        instrWord,
   input wire logic               instrDone,
   input wire logic               fetchAlignTrap,
   input wire epd_pkg::epd_fmt_t  instrFmt
);
   timeunit 1ns;
   timeprecision 1ns;
   import epd_pkg::*;
   logic     extOk, fetchBad, dataBad, dataTrapExp;
   epd_fmt_t fmtExp;
   // --------------------------------
   // Expected outcomes, kept apart from the design
   // --------------------------------
   assign extOk       = extLoadValid && extLoadReady && extLoadAddr[3:0] == 4'h0;
   assign fetchBad    = fetchAddr[1:0] != 2'h0;
   assign dataTrapExp = dataAccValid && dataBad;
   assign fmtExp      = (instrWord[31:30] == 2'h1) ? FMT_CALL :
                        (instrWord[31:30] == 2'h0) ? FMT_SET_HIGH_BR : FMT_OTHER;
   // Size table; unknown size codes always trap
   always_comb begin
      case (dataAccSize)
         SZ_BYTE:   dataBad = 1'b0;
         SZ_HALF:   dataBad = dataAccAddr[0];
         SZ_WORD:   dataBad = |dataAccAddr[1:0];
         SZ_DOUBLE: dataBad = |dataAccAddr[2:0];
         SZ_EXT:    dataBad = |dataAccAddr[3:0];
         default:   dataBad = 1'b1;
      endcase
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // --------------------------------
   // Properties
   // --------------------------------
   property p_start;
      extOk |=> memReq && memAddr == $past(extLoadAddr) && !extLoadReady;
   endproperty
   a_start: assert property (p_start) else $error("load start wrong");
   property p_trap;
      extLoadValid && extLoadReady && extLoadAddr[3:0] != 4'h0 |=> extAlignTrap && !memReq;
   endproperty
   a_trap: assert property (p_trap) else $error("no align trap");
   property p_refuse; extLoadValid && !extLoadReady |=> !extAlignTrap; endproperty
   a_refuse: assert property (p_refuse) else $error("busy request acted on");
   property p_hold; memReq && !memAck |=> memReq && $stable(memAddr); endproperty
   a_hold: assert property (p_hold) else $error("read dropped early");
   property p_step; memReq && memAck |=> !memReq || memAddr == $past(memAddr) + 32'h4; endproperty
   a_step: assert property (p_step) else $error("word order wrong");
   property p_finish; extOk |-> ##[5:400] extDone; endproperty
   a_finish: assert property (p_finish) else $error("load never done");
   property p_last;
      extDone |-> regWrEn && regWrIdx[0] && regWrData == 32'h0 ##1 extLoadReady;
   endproperty
   a_last: assert property (p_last) else $error("fourth word wrong");
   property p_data; 1'b1 |=> dataAlignTrap == $past(dataTrapExp); endproperty
   a_data: assert property (p_data) else $error("data trap wrong");
   property p_instr; instrValid |=> instrDone && fetchAlignTrap == $past(fetchBad); endproperty
   a_instr: assert property (p_instr) else $error("fetch answer wrong");
   property p_fmt; instrValid && !fetchBad |=> instrFmt == $past(fmtExp); endproperty
   a_fmt: assert property (p_fmt) else $error("format wrong");
   c_load: cover property (extDone);
   c_trap: cover property (extAlignTrap);
   c_fetch: cover property (fetchAlignTrap && instrDone);
endmodule : epd_ext_load_props
bind epd_ext_load epd_ext_load_props u_props (.*);
`default_nettype wire

// >>> bench/epd_mem_model.sv
// Purpose: Behavioural memory answering single-word reads
// Assumes: Bench loads the table; index from address bits 5:2
// Notes:   Idle read data toggles so a stale word never matches
`default_nettype none
module epd_mem_model (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   // Read port
   input  wire logic        memReq,
   input  wire logic [31:0] memAddr,
   output logic             memAck,
   output logic [31:0]      memRdData,
   // Answer delay
   input  wire logic [3:0]  waitCyc
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] mem [0:15];
   logic [3:0]  cnt;
   // --------------------------------
   // One answer per read after the set delay
   // --------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt       <= 4'h0;
         memAck    <= 1'b0;
         memRdData <= 32'h0;
      end else begin
         memAck    <= 1'b0;
         memRdData <= ~memRdData;
         if (memReq && !memAck && cnt >= waitCyc) begin
            memAck    <= 1'b1;
            memRdData <= mem[memAddr[5:2]];
            cnt       <= 4'h0;
         end else if (memReq && !memAck) begin
            cnt <= cnt + 4'h1;
         end
      end
   end
endmodule : epd_mem_model
`default_nettype wire

// >>> bench/epd_ext_load_test.sv
// Purpose: Self-checking bench for the extended load and format decode
// Assumes: Memory partner model answers the reads
// Notes:   Each scenario task drives and judges before it returns
`default_nettype none
module epd_ext_load_test;
   timeunit 1ns;
   timeprecision 1ns;
   import epd_pkg::*;
   logic        ref_clk, reset_n, extLoadValid, extLoadReady, memReq, memAck, regWrEn;
   logic        extDone, extIsNan, extIsSignaling, extIsInf, extAlignTrap, dataAccValid;
   logic        dataAlignTrap, instrValid, instrDone, fetchAlignTrap, instrUsesImm;
   logic [31:0] extLoadAddr, memAddr, memRdData, regWrData, dataAccAddr, fetchAddr, instrWord;
   logic [15:0] extExpUnbiased;
   logic [4:0]  extLoadDest, regWrIdx, instrSrc1, instrSrc2;
   logic [3:0]  waitCyc;
   epd_size_t   dataAccSize;
   epd_fmt_t    instrFmt;
   int          errCount, nCompared;
   epd_ext_load uut (.*);
   epd_mem_model mdl (.ref_clk(ref_clk), .reset_n(reset_n), .memReq(memReq),
      .memAddr(memAddr), .memAck(memAck), .memRdData(memRdData), .waitCyc(waitCyc));
   // --------------------------------
   // Shared tasks
   // --------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      nCompared++;
      if (got !== exp) begin
         errCount++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask : chk
   task automatic endSim;
      if (errCount == 0 && nCompared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : endSim
   // Load one datum, poke a refused misaligned request while busy
   task automatic extLoad(input logic [31:0] a, input logic [4:0] d, input logic [3:0] w,
                          input logic [31:0] w0, w1, w2, w3);
      logic [31:0] ew [4];
      logic [14:0] e;
      logic [62:0] f;
      logic [4:0]  ix;
      logic        tr;
      int          k;
      ew = '{{w0[31:16], 16'h0}, w1, w2, 32'h0};
      e = w0[30:16];
      f = {w1[30:0], w2};
      for (k = 0; k < 4; k++) mdl.mem[a[5:2] + 4'(k)] = (k == 3) ? w3 : ew[k];
      mdl.mem[a[5:2]] = w0;
      @(posedge ref_clk);
      waitCyc      <= w;
      extLoadValid <= 1'b1;
      extLoadAddr  <= a;
      extLoadDest  <= d;
      @(posedge ref_clk);
      extLoadValid <= 1'b0;
      k = 0;
      tr = 1'b0;
      for (int n = 0; n < 300 && k < 4; n++) begin
         @(posedge ref_clk);
         extLoadValid <= (n == 0);
         extLoadAddr  <= a + 32'h1;
         #1;
         tr = tr | extAlignTrap;
         if (regWrEn === 1'b1) begin
            ix = {d[4:1], 1'b0} + 5'(k);
            chk(regWrIdx, ix, "write index");
            chk(regWrData, ew[k], "write data");
            k++;
         end
      end
      if (k < 4) begin
         chk(32'h0, 32'h1, "load timeout");
         endSim();
      end
      chk({tr, extDone}, 2'b01, "done or refusal");
      chk({extIsNan, extIsSignaling, extIsInf}, {e == 15'h7FFF && f != 0,
         e == 15'h7FFF && f != 0 && !w1[30], e == 15'h7FFF && f == 0}, "class");
      chk(extExpUnbiased, 16'({1'b0, e} - EXT_BIAS), "exponent");
   endtask : extLoad
   task automatic misLoad(input logic [31:0] a);
      @(posedge ref_clk);
      extLoadValid <= 1'b1;
      extLoadAddr  <= a;
      @(posedge ref_clk);
      extLoadValid <= 1'b0;
      #1;
      chk({extAlignTrap, memReq, extLoadReady}, 3'b101, "misaligned load");
   endtask : misLoad
   // Size codes 0 to 5 against every low address nibble
   task automatic dataChecks;
      logic [3:0] m;
      for (int s = 0; s < 6; s++) begin
         for (int o = 0; o < 16; o++) begin
            m = (s > 4) ? 4'hF : 4'((1 << s) - 1);
            @(posedge ref_clk);
            dataAccValid <= 1'b1;
            dataAccSize  <= epd_size_t'(3'(s));
            dataAccAddr  <= 32'h1000 + 32'(o);
            @(posedge ref_clk);
            #1;
            chk(dataAlignTrap, s > 4 || (4'(o) & m) != 0, "data trap");
         end
      end
      @(posedge ref_clk);
      dataAccValid <= 1'b0;
   endtask : dataChecks
   // Four opcodes, both immediate flags, aligned then misaligned
   task automatic instrChecks;
      logic [31:0] w;
      epd_fmt_t    f;
      logic [10:0] op;
      for (int i = 0; i < 16; i++) begin
         w = {2'(i), 16'hC3A5, i[2], 13'h1A6B};
         @(posedge ref_clk);
         instrValid <= 1'b1;
         instrWord  <= w;
         fetchAddr  <= 32'h4000 + {i[3], 1'b0};
         @(posedge ref_clk);
         #1;
         chk({instrDone, fetchAlignTrap}, {1'b1, i[3]}, "fetch");
         f = FMT_NONE;
         if (i < 8) begin
            f  = (w[31:30] == 2'h1) ? FMT_CALL :
                 (w[31:30] == 2'h0) ? FMT_SET_HIGH_BR : FMT_OTHER;
            op = {f != FMT_OTHER || w[13], w[18:14], w[4:0]};
         end
         chk(instrFmt, f, "format");
         chk({instrUsesImm, instrSrc1, instrSrc2}, op, "operands");
      end
      @(posedge ref_clk);
      instrValid <= 1'b0;
   endtask : instrChecks
   // --------------------------------
   // Clock and main sequence
   // --------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      {reset_n, extLoadValid, dataAccValid, instrValid, waitCyc, extLoadDest} = '0;
      {extLoadAddr, dataAccAddr, fetchAddr, instrWord} = '0;
      dataAccSize = SZ_BYTE;
      repeat (20) @(posedge ref_clk);
      reset_n <= 1'b1;
      extLoad(32'h100, 5'h05, 4'h0, 32'h4000_ABCD, 32'h8000_0001, 32'h1234_5678,
              32'hFFFF_FFFF);
      extLoad(32'h130, 5'h1F, 4'h3, 32'h7FFF_1234, 32'h4000_0000, 32'h0, 32'h5);
      extLoad(32'h120, 5'h00, 4'h1, 32'hFFFF_0000, 32'h0, 32'h1, 32'h0);
      extLoad(32'h110, 5'h0C, 4'h0, 32'h7FFF_0000, 32'h8000_0000, 32'h0, 32'h9);
      misLoad(32'h108);
      misLoad(32'h104);
      dataChecks();
      instrChecks();
      endSim();
   end
endmodule : epd_ext_load_test
`default_nettype wire
